// *** shared/pmic_psc_consts.vh ***
// constants for the power state controller: map, fields, codes, timing
`ifndef PMIC_PSC_CONSTS_VH
`define PMIC_PSC_CONSTS_VH

// timing
`define CLK_MHZ 40
`define SLOT_TIME_US 2000
`define SLOT_CYC (`SLOT_TIME_US * `CLK_MHZ)
`define FAIL_TIME_MS 2000
`define FAIL_CYC (`FAIL_TIME_MS * 1000 * `CLK_MHZ)
`define DLY_UNIT_US 1000
`define DLY_UNIT_CYC (`DLY_UNIT_US * `CLK_MHZ)
`define N_SLOTS 3'h5
`define LAST_IDX 3'h4

// register addresses (15-bit control interface address)
`define ADDR_POWER_STATE 15'h4003
`define ADDR_SYS_STATUS 15'h400d
`define ADDR_BACKUP_CTRL 15'h4010
`define ADDR_SCRATCH 15'h4011
`define ADDR_PROG_KEY 15'h4012

// field positions
`define BIT_SYS_ON 15
`define BIT_SLEEP 14
`define DLY_MSB 11
`define DLY_LSB 10
`define BIT_UNCLOCKED 0
`define BIT_AON_KEEP 1

// reset values
`define PWR_DLY_RST 2'h0
`define SCRATCH_RST 16'h0000
`define BACKUP_CTRL_RST 2'h0

// program entry/exit key pair
`define PROG_KEY1 16'h5a5a
`define PROG_KEY2 16'ha5a5

// readable main state codes
`define CODE_OFF 5'h00
`define CODE_PROG 5'h0b
`define CODE_SLEEP 5'h1c
`define CODE_ON 5'h1f
`define CODE_SEQ_ON 5'h01
`define CODE_SEQ_OFF 5'h02
`define CODE_SEQ_SLEEP 5'h03
`define CODE_SEQ_WAKE 5'h04
`define CODE_BACKUP 5'h05
`define CODE_NOPWR 5'h06

`endif

// *** hw/sync2.v ***
// two flip-flop synchroniser for a bus of independent levels
module sync2 #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire sys_clk,
   input wire srst,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q;

   always @(posedge sys_clk) begin
      if (srst) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // sync2

// *** hw/pmic_power_state_controller.v ***
// main power state machine with timeslot sequencer and spi register port
`include "pmic_psc_consts.vh"

module pmic_power_state_controller #(
   parameter N_SUP = 10,
   parameter TW = 27,
   parameter SLOT_CYCLES = `SLOT_CYC,
   parameter FAIL_CYCLES = `FAIL_CYC,
   parameter DLY_UNIT_CYCLES = `DLY_UNIT_CYC
) (
   input wire sys_clk,
   input wire srst,
   input wire on_pin,
   input wire core_supply_por_ok,
   input wire core_supply_reset_ok,
   input wire wdog_off_req,
   input wire [N_SUP-1:0] supply_good,
   input wire cfg_from_bootstrap_eeprom,
   input wire [3*N_SUP-1:0] otp_on_slots,
   input wire [3*N_SUP-1:0] otp_sleep_slots,
   input wire [3*N_SUP-1:0] eeprom_on_slots,
   input wire [3*N_SUP-1:0] eeprom_sleep_slots,
   input wire spi_cs_n,
   input wire spi_sclk,
   input wire spi_mosi,
   output reg spi_miso_q,
   output reg spi_miso_oe_q,
   output reg [N_SUP-1:0] supply_en_q,
   output reg always_on_regulator_en_q,
   output reg reset_pin_n_q,
   output reg rtc_run_q,
   output reg rtc_freeze_q,
   output reg [4:0] main_state_q,
   output reg [3:0] enter_done_q,
   output reg seq_fail_q
);
   localparam ST_NOPWR = 3'h0;
   localparam ST_BACKUP = 3'h1;
   localparam ST_OFF = 3'h2;
   localparam ST_ON = 3'h3;
   localparam ST_SLEEP = 3'h4;
   localparam ST_PROG = 3'h5;
   localparam ST_DELAY = 3'h6;
   localparam ST_SEQ = 3'h7;

   localparam K_ON = 2'h0;
   localparam K_OFF = 2'h1;
   localparam K_SLEEP = 2'h2;
   localparam K_WAKE = 2'h3;

   // 32-bit copies first, then cut to the timer width on purpose
   localparam [31:0] SLOT_M1_W = SLOT_CYCLES - 1;
   localparam [31:0] FAIL_M1_W = FAIL_CYCLES - 1;
   localparam [31:0] DLY_U_W = DLY_UNIT_CYCLES;
   localparam [TW-1:0] SLOT_M1 = SLOT_M1_W[TW-1:0];
   localparam [TW-1:0] FAIL_M1 = FAIL_M1_W[TW-1:0];
   localparam [TW-1:0] DLY_U = DLY_U_W[TW-1:0];
   localparam SW = 6 + N_SUP;

   // ---------------- input synchronisers ----------------
   wire [SW-1:0] sync_out;
   wire on_s;
   wire por_s;
   wire rstok_s;
   wire cs_n_s;
   wire sclk_s;
   wire mosi_s;
   wire [N_SUP-1:0] good_s;

   // core supplies assumed good, supply_good low and chip select idle while in reset
   sync2 #(
      .W(SW),
      .RST_VAL({1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, {N_SUP{1'b0}}})
   ) u_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .d({on_pin, core_supply_por_ok, core_supply_reset_ok, spi_cs_n,
          spi_sclk, spi_mosi, supply_good}),
      .q(sync_out)
   );
   assign {on_s, por_s, rstok_s, cs_n_s, sclk_s, mosi_s, good_s} = sync_out;

   reg on_prev_q;
   reg sclk_prev_q;
   wire on_rise = on_s & ~on_prev_q;
   wire sclk_rise = sclk_s & ~sclk_prev_q;
   wire sclk_fall = ~sclk_s & sclk_prev_q;

   always @(posedge sys_clk) begin
      if (srst) begin
         on_prev_q <= 1'b0;
         sclk_prev_q <= 1'b0;
      end else begin
         on_prev_q <= on_s;
         sclk_prev_q <= sclk_s;
      end
   end

   // ---------------- state registers ----------------
   reg [2:0] state_q;
   reg [1:0] kind_q;
   reg [2:0] idx_q;
   reg [TW-1:0] tmr_q;
   reg [TW-1:0] fail_q;

   // register file
   reg [1:0] pwr_dly_q;
   reg unclocked_q;
   reg aon_keep_q;
   reg [15:0] scratch_q;
   reg prog_arm_q;

   // spi write commit
   reg wr_q;
   reg [14:0] wr_addr_q;
   reg [15:0] wr_data_q;

   wire lost = (state_q == ST_NOPWR) | (state_q == ST_BACKUP);
   wire busy = (state_q == ST_DELAY) | (state_q == ST_SEQ);
   wire sys_on = (state_q == ST_ON) | (state_q == ST_SLEEP) |
                 (busy & (kind_q != K_ON));

   wire ps_wr = wr_q & (wr_addr_q == `ADDR_POWER_STATE);
   wire off_wr = ps_wr & ~wr_data_q[`BIT_SYS_ON];
   wire sleep_wr = ps_wr & wr_data_q[`BIT_SYS_ON] &
                   wr_data_q[`BIT_SLEEP];
   wire wake_wr = ps_wr & wr_data_q[`BIT_SYS_ON] &
                  ~wr_data_q[`BIT_SLEEP];
   wire key_wr = wr_q & (wr_addr_q == `ADDR_PROG_KEY);
   wire prog_go = key_wr & prog_arm_q &
                  (wr_data_q == `PROG_KEY2);

   // ---------------- slot matching ----------------
   wire [3*N_SUP-1:0] on_slots = cfg_from_bootstrap_eeprom ?
                                 eeprom_on_slots : otp_on_slots;
   wire [3*N_SUP-1:0] sleep_slots = cfg_from_bootstrap_eeprom ?
                                    eeprom_sleep_slots :
                                    otp_sleep_slots;
   wire use_on_tab = (kind_q == K_ON) | (kind_q == K_OFF);
   wire [3*N_SUP-1:0] act_slots = use_on_tab ? on_slots : sleep_slots;
   wire ascend = (kind_q == K_ON) | (kind_q == K_SLEEP);
   // off and wake walk the slots backwards
   wire [2:0] cur_slot = ascend ? idx_q + 3'h1 : `N_SLOTS - idx_q;
   wire powering = (kind_q == K_ON) | (kind_q == K_WAKE);
   // in on and wake sequences a slot stretches until every enabled supply reports good
   wire settled = ~powering | (&(~supply_en_q | good_s));
   wire [TW-1:0] dly_cyc = {{(TW-2){1'b0}}, pwr_dly_q} * DLY_U;

   reg [N_SUP-1:0] slot_hit;
   reg [N_SUP-1:0] on_assigned;
   integer i;

   always @* begin
      slot_hit = {N_SUP{1'b0}};
      on_assigned = {N_SUP{1'b0}};
      for (i = 0; i < N_SUP; i = i + 1) begin
         slot_hit[i] = (act_slots[3*i +: 3] == cur_slot);
         on_assigned[i] = (on_slots[3*i +: 3] != 3'h0);
      end
   end

   // ---------------- main state machine ----------------
   always @(posedge sys_clk) begin
      if (srst) begin
         state_q <= ST_OFF;
         kind_q <= K_ON;
         idx_q <= 3'h0;
         tmr_q <= {TW{1'b0}};
         fail_q <= {TW{1'b0}};
         supply_en_q <= {N_SUP{1'b0}};
         enter_done_q <= 4'h0;
         seq_fail_q <= 1'b0;
      end else begin
         enter_done_q <= 4'h0;
         seq_fail_q <= 1'b0;
         if (!por_s) begin
            state_q <= ST_NOPWR;
            supply_en_q <= {N_SUP{1'b0}};
         end else if (!rstok_s) begin
            // supply drops override any running sequence
            if (state_q != ST_BACKUP) begin
               enter_done_q[3] <= 1'b1;
            end
            state_q <= ST_BACKUP;
            supply_en_q <= {N_SUP{1'b0}};
         end else begin
            case (state_q)
               ST_NOPWR, ST_BACKUP: begin
                  state_q <= ST_OFF;
                  enter_done_q[0] <= 1'b1;
               end
               ST_OFF: begin
                  supply_en_q <= {N_SUP{1'b0}};
                  if (on_rise) begin
                     state_q <= ST_SEQ;
                     kind_q <= K_ON;
                     idx_q <= 3'h0;
                     tmr_q <= {TW{1'b0}};
                     fail_q <= {TW{1'b0}};
                  end else if (prog_go) begin
                     state_q <= ST_PROG;
                  end
               end
               ST_PROG: begin
                  if (prog_go) begin
                     state_q <= ST_OFF;
                     enter_done_q[0] <= 1'b1;
                  end
               end
               ST_ON: begin
                  if (on_rise | wdog_off_req | off_wr) begin
                     state_q <= ST_DELAY;
                     kind_q <= K_OFF;
                     tmr_q <= {TW{1'b0}};
                     // unsequenced supplies drop at once on an off event
                     supply_en_q <= supply_en_q & on_assigned;
                  end else if (sleep_wr) begin
                     state_q <= ST_DELAY;
                     kind_q <= K_SLEEP;
                     tmr_q <= {TW{1'b0}};
                  end
               end
               ST_SLEEP: begin
                  if (wdog_off_req | off_wr) begin
                     state_q <= ST_DELAY;
                     kind_q <= K_OFF;
                     tmr_q <= {TW{1'b0}};
                     supply_en_q <= supply_en_q & on_assigned;
                  end else if (wake_wr | on_rise) begin
                     state_q <= ST_DELAY;
                     kind_q <= K_WAKE;
                     tmr_q <= {TW{1'b0}};
                  end
               end
               ST_DELAY: begin
                  // new requests are not looked at here
                  if (tmr_q >= dly_cyc) begin
                     state_q <= ST_SEQ;
                     idx_q <= 3'h0;
                     tmr_q <= {TW{1'b0}};
                  end else begin
                     tmr_q <= tmr_q + 1'b1;
                  end
               end
               ST_SEQ: begin
                  if (kind_q == K_ON) begin
                     fail_q <= fail_q + 1'b1;
                  end
                  if (kind_q == K_ON && fail_q == FAIL_M1) begin
                     state_q <= ST_OFF;
                     supply_en_q <= {N_SUP{1'b0}};
                     seq_fail_q <= 1'b1;
                     enter_done_q[0] <= 1'b1;
                  end else if (tmr_q == {TW{1'b0}}) begin
                     tmr_q <= {{(TW-1){1'b0}}, 1'b1};
                     if (powering) begin
                        supply_en_q <= supply_en_q | slot_hit;
                     end else begin
                        supply_en_q <= supply_en_q & ~slot_hit;
                     end
                  end else if (tmr_q >= SLOT_M1 && settled) begin
                     tmr_q <= {TW{1'b0}};
                     if (idx_q == `LAST_IDX) begin
                        case (kind_q)
                           K_ON, K_WAKE: begin
                              state_q <= ST_ON;
                              enter_done_q[1] <= 1'b1;
                           end
                           K_SLEEP: begin
                              state_q <= ST_SLEEP;
                              enter_done_q[2] <= 1'b1;
                           end
                           default: begin
                              state_q <= ST_OFF;
                              supply_en_q <= {N_SUP{1'b0}};
                              enter_done_q[0] <= 1'b1;
                           end
                        endcase
                     end else begin
                        idx_q <= idx_q + 3'h1;
                     end
                  end else begin
                     tmr_q <= tmr_q + 1'b1;
                  end
               end
               default: begin
                  state_q <= ST_OFF;
               end
            endcase
         end
      end
   end

   // ---------------- state-driven outputs ----------------
   always @(posedge sys_clk) begin
      if (srst) begin
         main_state_q <= `CODE_OFF;
         reset_pin_n_q <= 1'b0;
         rtc_run_q <= 1'b1;
         rtc_freeze_q <= 1'b0;
         always_on_regulator_en_q <= 1'b0;
      end else begin
         case (state_q)
            ST_OFF: main_state_q <= `CODE_OFF;
            ST_ON: main_state_q <= `CODE_ON;
            ST_SLEEP: main_state_q <= `CODE_SLEEP;
            ST_PROG: main_state_q <= `CODE_PROG;
            ST_BACKUP: main_state_q <= `CODE_BACKUP;
            ST_NOPWR: main_state_q <= `CODE_NOPWR;
            default: begin
               case (kind_q)
                  K_ON: main_state_q <= `CODE_SEQ_ON;
                  K_OFF: main_state_q <= `CODE_SEQ_OFF;
                  K_SLEEP: main_state_q <= `CODE_SEQ_SLEEP;
                  default: main_state_q <= `CODE_SEQ_WAKE;
               endcase
            end
         endcase
         // processor held in reset until the on sequence completes
         reset_pin_n_q <= sys_on;
         rtc_run_q <= (state_q != ST_NOPWR) &
                      ~((state_q == ST_BACKUP) & unclocked_q);
         rtc_freeze_q <= (state_q == ST_BACKUP) & unclocked_q;
         always_on_regulator_en_q <= ~lost &
            ((state_q != ST_OFF) | aon_keep_q);
      end
   end

   // ---------------- register file ----------------
   always @(posedge sys_clk) begin
      if (srst || lost) begin
         pwr_dly_q <= `PWR_DLY_RST;
         prog_arm_q <= 1'b0;
      end else if (wr_q) begin
         if (wr_addr_q == `ADDR_POWER_STATE) begin
            pwr_dly_q <= wr_data_q[`DLY_MSB:`DLY_LSB];
         end
         if (key_wr) begin
            prog_arm_q <= (wr_data_q == `PROG_KEY1) &
                          ((state_q == ST_OFF) | (state_q == ST_PROG));
         end
      end
   end

   // scratch and backup options survive backup, not a loss of power
   always @(posedge sys_clk) begin
      if (srst || state_q == ST_NOPWR) begin
         scratch_q <= `SCRATCH_RST;
         {aon_keep_q, unclocked_q} <= `BACKUP_CTRL_RST;
      end else if (wr_q && wr_addr_q == `ADDR_SCRATCH) begin
         scratch_q <= wr_data_q;
      end else if (wr_q && wr_addr_q == `ADDR_BACKUP_CTRL) begin
         unclocked_q <= wr_data_q[`BIT_UNCLOCKED];
         aon_keep_q <= wr_data_q[`BIT_AON_KEEP];
      end
   end

   reg [15:0] rd_data;

   // status field has no write path at all
   always @* begin
      case (wr_addr_q)
         `ADDR_POWER_STATE: rd_data = {sys_on, state_q == ST_SLEEP, 2'h0,
                                       pwr_dly_q, 10'h000};
         `ADDR_SYS_STATUS: rd_data = {11'h000, main_state_q};
         `ADDR_BACKUP_CTRL: rd_data = {14'h0000, aon_keep_q, unclocked_q};
         `ADDR_SCRATCH: rd_data = scratch_q;
         `ADDR_PROG_KEY: rd_data = {15'h0000, prog_arm_q};
         default: rd_data = 16'h0000;
      endcase
   end

   // ---------------- spi slave, mode 0, 32-bit frames ----------------
   // sclk is oversampled, so it must stay below about sys_clk / 6
   reg [5:0] bitcnt_q;
   reg [15:0] shreg_q;
   reg rd_q;
   reg [15:0] obuf_q;

   always @(posedge sys_clk) begin
      if (srst || lost) begin
         bitcnt_q <= 6'h00;
         shreg_q <= 16'h0000;
         rd_q <= 1'b0;
         obuf_q <= 16'h0000;
         wr_q <= 1'b0;
         wr_addr_q <= 15'h0000;
         wr_data_q <= 16'h0000;
         spi_miso_q <= 1'b0;
         spi_miso_oe_q <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         if (cs_n_s) begin
            bitcnt_q <= 6'h00;
            rd_q <= 1'b0;
            spi_miso_oe_q <= 1'b0;
         end else begin
            if (sclk_rise) begin
               shreg_q <= {shreg_q[14:0], mosi_s};
               bitcnt_q <= bitcnt_q + 6'h01;
               if (bitcnt_q == 6'h0f) begin
                  rd_q <= shreg_q[14];
                  wr_addr_q <= {shreg_q[13:0], mosi_s};
               end
               if (bitcnt_q == 6'h1f && !rd_q) begin
                  wr_q <= 1'b1;
                  wr_data_q <= {shreg_q[14:0], mosi_s};
               end
            end
            if (bitcnt_q == 6'h10 && sclk_rise == 1'b0 &&
                sclk_fall == 1'b0 && rd_q && !spi_miso_oe_q) begin
               obuf_q <= rd_data;
               spi_miso_oe_q <= 1'b1;
            end else if (sclk_fall && spi_miso_oe_q) begin
               spi_miso_q <= obuf_q[15];
               obuf_q <= {obuf_q[14:0], 1'b0};
            end
         end
      end
   end
endmodule // pmic_power_state_controller

// *** testbench/pmic_psc_monitor.sv ***
// port assertions for the power state controller
module pmic_psc_monitor #(
   parameter N_SUP = 10
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic on_pin,
   input wire logic core_supply_por_ok,
   input wire logic core_supply_reset_ok,
   input wire logic [N_SUP-1:0] supply_en_q,
   input wire logic reset_pin_n_q,
   input wire logic rtc_run_q,
   input wire logic rtc_freeze_q,
   input wire logic [4:0] main_state_q,
   input wire logic [3:0] enter_done_q,
   input wire logic seq_fail_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence on_rise_in_off;
      main_state_q == 5'h00 && core_supply_reset_ok && !on_pin ##1 on_pin;
   endsequence
   sequence backup_held;
      (core_supply_por_ok && !core_supply_reset_ok) [*4];
   endsequence
   chk_on_starts: assert property (
      on_rise_in_off |-> ##[2:6] main_state_q == 5'h01)
      else $error("on edge ignored in off");
   chk_on_code: assert property (
      enter_done_q[1] |-> ##[0:2] (main_state_q == 5'h1f && reset_pin_n_q))
      else $error("on entry wrong");
   chk_sleep_code: assert property (
      enter_done_q[2] |-> ##[0:2] main_state_q == 5'h1c)
      else $error("sleep entry wrong");
   chk_off_reset: assert property (
      enter_done_q[0] |-> ##[0:2] (main_state_q == 5'h00 && !reset_pin_n_q))
      else $error("off entry wrong");
   // supplies rise in the same cycle that the code leaves off
   chk_off_supplies: assert property (
      main_state_q == 5'h00 && $past(main_state_q) == 5'h00
      |-> $past(supply_en_q) == '0)
      else $error("supply on while off");
   chk_backup_code: assert property (
      backup_held |-> ##[0:3] main_state_q == 5'h05)
      else $error("no backup on low supply");
   chk_nopwr_entry: assert property (
      !core_supply_por_ok [*4] |-> ##[0:3]
      (main_state_q == 5'h06 && supply_en_q == '0 && !rtc_run_q))
      else $error("por loss not handled");
   chk_freeze_in_backup: assert property (
      rtc_freeze_q |-> (!rtc_run_q && main_state_q == 5'h05))
      else $error("frozen rtc still runs");
   chk_fail_off: assert property (
      seq_fail_q |-> ##[0:2] (enter_done_q[0] && !reset_pin_n_q))
      else $error("failure did not force off");
endmodule // pmic_psc_monitor

bind pmic_power_state_controller pmic_psc_monitor #(.N_SUP(N_SUP)) mon (
   .sys_clk(sys_clk), .srst(srst), .on_pin(on_pin),
   .core_supply_por_ok(core_supply_por_ok),
   .core_supply_reset_ok(core_supply_reset_ok),
   .supply_en_q(supply_en_q), .reset_pin_n_q(reset_pin_n_q),
   .rtc_run_q(rtc_run_q), .rtc_freeze_q(rtc_freeze_q),
   .main_state_q(main_state_q), .enter_done_q(enter_done_q),
   .seq_fail_q(seq_fail_q));

// *** testbench/spi_host_model.sv ***
// host processor model on the spi register port
module spi_host_model (
   output logic cs_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b1;
   end
   // read data sampled late in the high phase; undriven reads as unknown
   task automatic xfer(input logic [31:0] f, output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      cs_n = 1'b0;
      for (i = 31; i >= 0; i--) begin
         mosi = f[i];
         #100 sclk = 1'b1;
         #100;
         if (i < 16) rd = {rd[14:0], miso_oe ? miso : 1'bx};
         sclk = 1'b0;
      end
      #50 mosi = ~mosi;
      cs_n = 1'b1;
      #1000;
   endtask
endmodule // spi_host_model

// *** testbench/tb_top.sv ***
// self-checking bench for the power state controller
`include "pmic_psc_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N = 10;
   logic sys_clk = 0, srst = 1, on_pin = 0, wdog_off_req = 0;
   logic core_supply_por_ok = 1, core_supply_reset_ok = 1;
   logic cfg_from_bootstrap_eeprom = 0, good_on = 1, fail_seen = 0;
   logic [N-1:0] supply_good = '0, on_mask = '0, eep_mask = '0;
   logic [N-1:0] slp_mask = '0;
   logic [3*N-1:0] otp_on_slots = '0, otp_sleep_slots = '0;
   logic [3*N-1:0] eeprom_on_slots = '0, eeprom_sleep_slots = '0;
   logic [3:0] ev = '0;
   wire spi_cs_n, spi_sclk, spi_mosi, spi_miso_q, spi_miso_oe_q;
   wire always_on_regulator_en_q, reset_pin_n_q, rtc_run_q;
   wire rtc_freeze_q, seq_fail_q;
   wire [N-1:0] supply_en_q;
   wire [4:0] main_state_q;
   wire [3:0] enter_done_q;
   int fail_count = 0, samples_checked = 0;
   // short counts keep the run brief
   pmic_power_state_controller #(.N_SUP(N), .SLOT_CYCLES(8),
      .FAIL_CYCLES(200), .DLY_UNIT_CYCLES(4)) uut (
      .sys_clk(sys_clk), .srst(srst), .on_pin(on_pin),
      .core_supply_por_ok(core_supply_por_ok),
      .core_supply_reset_ok(core_supply_reset_ok),
      .wdog_off_req(wdog_off_req), .supply_good(supply_good),
      .cfg_from_bootstrap_eeprom(cfg_from_bootstrap_eeprom),
      .otp_on_slots(otp_on_slots), .otp_sleep_slots(otp_sleep_slots),
      .eeprom_on_slots(eeprom_on_slots),
      .eeprom_sleep_slots(eeprom_sleep_slots),
      .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
      .spi_miso_q(spi_miso_q), .spi_miso_oe_q(spi_miso_oe_q),
      .supply_en_q(supply_en_q),
      .always_on_regulator_en_q(always_on_regulator_en_q),
      .reset_pin_n_q(reset_pin_n_q), .rtc_run_q(rtc_run_q),
      .rtc_freeze_q(rtc_freeze_q), .main_state_q(main_state_q),
      .enter_done_q(enter_done_q), .seq_fail_q(seq_fail_q));
   spi_host_model host (.cs_n(spi_cs_n), .sclk(spi_sclk),
      .mosi(spi_mosi), .miso(spi_miso_q), .miso_oe(spi_miso_oe_q));
   always #12.5 sys_clk = ~sys_clk;
   // supplies report good a cycle after enable unless stalled
   always @(posedge sys_clk) begin
      supply_good <= good_on ? supply_en_q : '0;
      ev <= ev | enter_done_q;
      fail_seen <= fail_seen | seq_fail_q;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic st(input int e);
      chk(16'(main_state_q), 16'(e));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wr(input logic [14:0] a, input logic [15:0] d);
      logic [15:0] r;
      // frames start off the sampling edge of the design clock
      @(negedge sys_clk);
      host.xfer({1'b0, a, d}, r);
   endtask
   task automatic rd(input logic [14:0] a, input logic [15:0] e);
      logic [15:0] r;
      @(negedge sys_clk);
      host.xfer({1'b1, a, 16'h0000}, r);
      chk(r, e);
   endtask
   task automatic wait_ev(input int b);
      int k;
      for (k = 0; k < 3000 && ev[b] !== 1'b1; k++) @(negedge sys_clk);
      chk(16'(k < 3000), 16'h0001);
      ev = '0;
      cyc(3);
   endtask
   task automatic pin;
      @(posedge sys_clk) on_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      on_pin <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #1ms;
      fail_count++;
      end_of_test();
   end
   initial begin
      int i, s;
      logic [15:0] sd;
      void'($urandom(51371));
      for (i = 0; i < N; i++) begin
         s = $urandom % 6;
         otp_on_slots[3*i +: 3] <= 3'(s);
         on_mask[i] = s != 0;
         s = $urandom % 6;
         otp_sleep_slots[3*i +: 3] <= 3'(s);
         slp_mask[i] = s != 0;
         s = (i == 0) ? 1 : $urandom % 6;
         eeprom_on_slots[3*i +: 3] <= 3'(s);
         eep_mask[i] = s != 0;
      end
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      cyc(3);
      st(`CODE_OFF);
      chk(16'(reset_pin_n_q), 16'h0000);
      chk(16'(always_on_regulator_en_q), 16'h0000);
      rd(`ADDR_SYS_STATUS, 16'h0000);
      wr(`ADDR_POWER_STATE, 16'h8000);
      cyc(60);
      st(`CODE_OFF);
      $display("test reset done");
      pin();
      wait_ev(1);
      st(`CODE_ON);
      chk(16'(supply_en_q), 16'(on_mask));
      chk(16'(reset_pin_n_q), 16'h0001);
      chk(16'(always_on_regulator_en_q), 16'h0001);
      wr(`ADDR_SYS_STATUS, 16'h0000);
      rd(`ADDR_SYS_STATUS, 16'h001f);
      wr(`ADDR_POWER_STATE, 16'hcc00);
      wait_ev(2);
      st(`CODE_SLEEP);
      chk(16'(supply_en_q), 16'(on_mask & ~slp_mask));
      wr(`ADDR_POWER_STATE, 16'h8c00);
      wait_ev(1);
      st(`CODE_ON);
      chk(16'(supply_en_q), 16'(on_mask | slp_mask));
      @(posedge sys_clk) wdog_off_req <= 1'b1;
      @(posedge sys_clk) wdog_off_req <= 1'b0;
      wait_ev(0);
      st(`CODE_OFF);
      chk(16'(supply_en_q), 16'h0000);
      $display("test on sleep wake done");
      pin();
      wait_ev(1);
      wr(`ADDR_POWER_STATE, 16'h0c00);
      pin();
      wait_ev(0);
      cyc(80);
      st(`CODE_OFF);
      for (i = 0; i < 2; i++) begin
         wr(`ADDR_PROG_KEY, `PROG_KEY1);
         wr(`ADDR_PROG_KEY, `PROG_KEY2);
         cyc(4);
         st(i == 0 ? `CODE_PROG : `CODE_OFF);
      end
      $display("test ignore and program done");
      sd = 16'($urandom);
      wr(`ADDR_BACKUP_CTRL, 16'h0003);
      chk(16'(always_on_regulator_en_q), 16'h0001);
      wr(`ADDR_SCRATCH, sd);
      @(posedge sys_clk) core_supply_reset_ok <= 1'b0;
      wait_ev(3);
      chk(16'({rtc_freeze_q, rtc_run_q}), 16'h0002);
      chk(16'(always_on_regulator_en_q), 16'h0000);
      @(posedge sys_clk) core_supply_reset_ok <= 1'b1;
      wait_ev(0);
      rd(`ADDR_SCRATCH, sd);
      rd(`ADDR_BACKUP_CTRL, 16'h0003);
      rd(`ADDR_POWER_STATE, 16'h0000);
      @(posedge sys_clk) core_supply_por_ok <= 1'b0;
      cyc(8);
      st(`CODE_NOPWR);
      chk(16'(rtc_run_q), 16'h0000);
      @(posedge sys_clk) core_supply_por_ok <= 1'b1;
      wait_ev(0);
      rd(`ADDR_SCRATCH, 16'h0000);
      chk(16'(always_on_regulator_en_q), 16'h0000);
      $display("test backup and no power done");
      @(posedge sys_clk) begin
         cfg_from_bootstrap_eeprom <= 1'b1;
         good_on <= 1'b0;
      end
      pin();
      wait_ev(0);
      chk(16'(fail_seen), 16'h0001);
      st(`CODE_OFF);
      @(posedge sys_clk) good_on <= 1'b1;
      pin();
      wait_ev(1);
      chk(16'(supply_en_q), 16'(eep_mask));
      pin();
      wait_ev(0);
      chk(16'({main_state_q, reset_pin_n_q}), 16'h0000);
      $display("test failure and eeprom done");
      end_of_test();
   end
endmodule // tb_top
